// ==== hw/ddr_sep_io_sram_pin_interface.sv ====
`timescale 1ns/1ps
module ddr_sep_io_sram_pin_interface #(
  parameter bit X36 = 1'b1,
  parameter int MEM_AW = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic k_clk,
  input wire logic dll_off_n,
  input wire sram_pins_pkg::link_cmd_t cmd,
  input wire logic [sram_pins_pkg::PIN_DW-1:0] wr_bus,
  output logic [sram_pins_pkg::PIN_DW-1:0] rd_bus,
  output logic out_valid_flag,
  output logic echo_pos,
  output logic echo_neg
);
  import sram_pins_pkg::*;

  // lanes in use for this variant
  localparam logic [PIN_DW-1:0] DMASK = X36 ? {PIN_DW{1'b1}} : NARROW_MASK;

  // ---------------- system clock side: loop lock timer ----------------

  // loop disable pin after two flops
  logic doff_s;

  bit_sync #(.RST_VAL(SYNC_RST_VAL)) u_doff_sync (
    .clk(clk),
    .rst(sys_rst),
    .d(dll_off_n),
    .q(doff_s)
  );

  // lock timer state
  typedef struct packed {
    logic [CNT_W-1:0] cnt; // cycles since loop enable
    logic locked;          // loop has lock, normal latency
  } dll_t;

  dll_t dll_r;
  dll_t dll_nxt;

  // timer: a low pin wipes all lock state, a high pin counts up to lock
  always_comb begin
    dll_nxt = dll_r;
    if (!doff_s) begin
      dll_nxt.cnt = '0;
      dll_nxt.locked = 1'b0;
    end else if (!dll_r.locked) begin
      if (dll_r.cnt == LOCK_LAST) begin
        dll_nxt.locked = 1'b1;
      end else begin
        dll_nxt.cnt = dll_r.cnt + 1'b1;
      end
    end
    if (sys_rst) begin
      dll_nxt = '0;
    end
  end

  // register the timer
  always_ff @(posedge clk) begin
    dll_r <= dll_nxt;
  end

  // ---------------- link side: runs on the true input clock ----------------

  // reset carried into the link domain
  logic k_rst;
  // lock state seen by the link logic
  logic dll_on;

  bit_sync #(.RST_VAL(KRST_RST_VAL)) u_krst_sync (
    .clk(k_clk),
    .rst(1'b0),
    .d(sys_rst),
    .q(k_rst)
  );

  // a level, so two flops suffice; latency mode may flip mid burst,
  // which is why the test keeps traffic clear of every mode change
  bit_sync #(.RST_VAL(SYNC_RST_VAL)) u_lock_sync (
    .clk(k_clk),
    .rst(k_rst),
    .d(dll_r.locked),
    .q(dll_on)
  );

  // link state on the true rising edge
  typedef struct packed {
    logic rd_p1;                 // read taken one edge ago
    logic rd_p2;                 // two edges ago
    logic rd_p3;                 // three edges ago
    logic [PIN_AW-1:0] rd_addr;  // registered read address
    logic [PIN_DW-1:0] rd_b0;    // fetched first beat
    logic [PIN_DW-1:0] rd_b1;    // fetched second beat
    logic wr_pend;               // write waiting for commit
    logic [PIN_AW-1:0] wr_addr;  // registered write address
    logic [PIN_DW-1:0] wr_b0;    // first write beat
  } core_t;

  core_t st_r;
  core_t st_nxt;

  // second write beat, caught on the complementary edge
  typedef struct packed {
    logic [PIN_DW-1:0] b1;
  } fall_cap_t;

  fall_cap_t fcap_r;
  fall_cap_t fcap_nxt;

  // array in flops; upper address bits alias, depth is a parameter
  logic [PIN_DW-1:0] mem [2**(MEM_AW+1)];

  // command decode
  logic rd_acc;
  logic w_acc;
  // read fetch with write-buffer bypass
  logic hit;
  logic [PIN_DW-1:0] fetch0;
  logic [PIN_DW-1:0] fetch1;
  // beats handed to the pin stage
  rd_beat_t rise_beat;
  rd_beat_t fall_beat;

  // array index of one beat of a burst
  function automatic logic [MEM_AW:0] idx(input logic [PIN_AW-1:0] a, input logic beat);
    return {a[MEM_AW-1:0], beat};
  endfunction

  // commands only on the true rising edge; a read right behind a read
  // would collide with its burst, so it is dropped
  always_comb begin
    rd_acc = !cmd.r_n && !st_r.rd_p1 && !k_rst;
    w_acc = !cmd.w_n && !k_rst;
  end

  // fetch, taking a write committed on this very edge from the buffer
  always_comb begin
    hit = st_r.wr_pend && (st_r.wr_addr[MEM_AW-1:0] == st_r.rd_addr[MEM_AW-1:0]);
    if (hit) begin
      fetch0 = st_r.wr_b0;
      fetch1 = fcap_r.b1;
    end else begin
      fetch0 = mem[idx(st_r.rd_addr, 1'b0)];
      fetch1 = mem[idx(st_r.rd_addr, 1'b1)];
    end
  end

  // link next state
  always_comb begin
    st_nxt = st_r;
    // read pipeline
    st_nxt.rd_p1 = rd_acc;
    st_nxt.rd_p2 = st_r.rd_p1;
    st_nxt.rd_p3 = st_r.rd_p2;
    // address only moves on a selected cycle
    if (rd_acc) begin
      st_nxt.rd_addr = cmd.addr;
    end
    if (st_r.rd_p1) begin
      st_nxt.rd_b0 = fetch0;
      st_nxt.rd_b1 = fetch1;
    end
    // write: address and first beat together
    st_nxt.wr_pend = w_acc;
    if (w_acc) begin
      st_nxt.wr_addr = cmd.addr;
      st_nxt.wr_b0 = wr_bus & DMASK;
    end
    if (k_rst) begin
      st_nxt = '0;
    end
  end

  // register the link state
  always_ff @(posedge k_clk) begin
    st_r <= st_nxt;
  end

  // second beat: upper lanes dropped on the narrow variant
  always_comb begin
    fcap_nxt.b1 = wr_bus & DMASK;
  end

  // complementary edge taken as the true clock falling edge
  always_ff @(negedge k_clk) begin
    fcap_r <= fcap_nxt;
  end

  // commit a burst one edge after its command, after both beats are in
  always_ff @(posedge k_clk) begin
    if (st_r.wr_pend) begin
      mem[idx(st_r.wr_addr, 1'b0)] <= st_r.wr_b0;
      mem[idx(st_r.wr_addr, 1'b1)] <= fcap_r.b1;
    end
  end

  // beat selection by latency mode; only the read pipe drives valid
  always_comb begin
    if (dll_on) begin
      // first beat at 2.5 cycles on the falling edge, second at 3
      fall_beat.vld = st_r.rd_p3;
      fall_beat.data = st_r.rd_p3 ? (st_r.rd_b0 & DMASK) : '0;
      rise_beat.vld = st_r.rd_p3;
      rise_beat.data = st_r.rd_p3 ? (st_r.rd_b1 & DMASK) : '0;
    end else begin
      // first beat on the next rising edge, second half a cycle later
      rise_beat.vld = st_r.rd_p1;
      rise_beat.data = st_r.rd_p1 ? (fetch0 & DMASK) : '0;
      fall_beat.vld = st_r.rd_p2;
      fall_beat.data = st_r.rd_p2 ? (st_r.rd_b1 & DMASK) : '0;
    end
  end

  // pin stage with the echo pair
  ddr_out_pair u_out (
    .k_clk(k_clk),
    .rst(k_rst),
    .rise_in(rise_beat),
    .fall_in(fall_beat),
    .rd_bus(rd_bus),
    .out_valid_flag(out_valid_flag),
    .echo_pos(echo_pos),
    .echo_neg(echo_neg)
  );

  // ---------------- checks ----------------

  property p_rd_take;
    @(posedge k_clk) disable iff (k_rst) rd_acc |=> st_r.rd_p1 && st_r.rd_addr == $past(cmd.addr);
  endproperty
  a_rd_take: assert property (p_rd_take) else $error("read not registered");

  property p_wr_take;
    @(posedge k_clk) disable iff (k_rst)
      w_acc |=> st_r.wr_pend && st_r.wr_addr == $past(cmd.addr) && st_r.wr_b0 == $past(wr_bus & DMASK);
  endproperty
  a_wr_take: assert property (p_wr_take) else $error("write not registered");

  property p_addr_idle;
    @(posedge k_clk) disable iff (k_rst)
      cmd.r_n && cmd.w_n |=> $stable(st_r.rd_addr) && $stable(st_r.wr_addr);
  endproperty
  a_addr_idle: assert property (p_addr_idle) else $error("address moved while deselected");

  property p_lat_on;
    @(posedge k_clk) disable iff (k_rst)
      rd_acc && dll_on ##1 dll_on ##1 dll_on |-> ##1 (fall_beat.vld && rise_beat.vld);
  endproperty
  a_lat_on: assert property (p_lat_on) else $error("normal read latency wrong");

  property p_lat_off;
    @(posedge k_clk) disable iff (k_rst)
      rd_acc && !dll_on ##1 !dll_on |-> rise_beat.vld ##1 (dll_on || fall_beat.vld);
  endproperty
  a_lat_off: assert property (p_lat_off) else $error("bypass read latency wrong");

  property p_rd_only;
    @(posedge k_clk) disable iff (k_rst)
      rise_beat.vld && dll_on && $past(dll_on, 3) |-> $past(rd_acc, 3);
  endproperty
  a_rd_only: assert property (p_rd_only) else $error("read data without read command");

  property p_narrow;
    @(posedge k_clk) disable iff (k_rst) !X36 |-> (rise_beat.data & ~NARROW_MASK) == '0;
  endproperty
  a_narrow: assert property (p_narrow) else $error("upper read lanes driven");

  property p_bypass;
    @(posedge clk) disable iff (sys_rst) !doff_s |=> !dll_r.locked && dll_r.cnt == '0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("lock kept while disabled");

  property p_lock;
    @(posedge clk) disable iff (sys_rst)
      $rose(dll_r.locked) |-> $past(dll_r.cnt) == LOCK_LAST && $past(doff_s);
  endproperty
  a_lock: assert property (p_lock) else $error("lock at wrong count");

  c_rd_on: cover property (@(posedge k_clk) disable iff (k_rst) rd_acc && dll_on);
  c_rd_off: cover property (@(posedge k_clk) disable iff (k_rst) rd_acc && !dll_on);
  c_wr_rd: cover property (@(posedge k_clk) disable iff (k_rst) w_acc && rd_acc);
  c_locked: cover property (@(posedge clk) disable iff (sys_rst) $rose(dll_r.locked));

endmodule

// ==== hw/sram_pins_pkg.sv ====
package sram_pins_pkg;

  // pin widths of the widest variant
  localparam int PIN_AW = 20;
  localparam int PIN_DW = 36;
  // lanes used by the narrow variant
  localparam int NARROW_DW = 18;

  // system clock rate, used to turn times into cycles
  localparam int CLK_MHZ = 100;
  // loop lock interval in ns (no figure is given, plain default)
  localparam int LOCK_NS = 20480;
  // lock interval in clk cycles, rounded up as a least time
  localparam int LOCK_CYC = (LOCK_NS * CLK_MHZ + 999) / 1000;
  // width of the lock counter
  localparam int CNT_W = 12;
  // last count value before lock is declared
  localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);

  // reset values
  localparam logic SYNC_RST_VAL = 1'b0;
  localparam logic KRST_RST_VAL = 1'b1;

  // mask that keeps only the narrow lanes
  localparam logic [PIN_DW-1:0] NARROW_MASK =
    {{(PIN_DW-NARROW_DW){1'b0}}, {NARROW_DW{1'b1}}};

  // command pins sampled on the true clock rising edge
  typedef struct packed {
    logic r_n;               // read select, active low
    logic w_n;               // write select, active low
    logic [PIN_AW-1:0] addr; // addr_in pins
  } link_cmd_t;

  // one read beat with its valid bit
  typedef struct packed {
    logic vld;
    logic [PIN_DW-1:0] data;
  } rd_beat_t;

endpackage

// ==== hw/bit_sync.sv ====
`timescale 1ns/1ps
module bit_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  import sram_pins_pkg::*;

  // two stages; the first is read by the second only
  typedef struct packed {
    logic s1;
    logic s2;
  } sync_t;

  sync_t st_r;
  sync_t st_nxt;

  // next state of the chain
  always_comb begin
    st_nxt.s1 = d;
    st_nxt.s2 = st_r.s1;
    if (rst) begin
      st_nxt = {RST_VAL, RST_VAL};
    end
  end

  // register the chain
  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  assign q = st_r.s2;

endmodule

// ==== hw/ddr_out_pair.sv ====
`timescale 1ns/1ps
module ddr_out_pair (
  input wire logic k_clk,
  input wire logic rst,
  input wire sram_pins_pkg::rd_beat_t rise_in,
  input wire sram_pins_pkg::rd_beat_t fall_in,
  output logic [sram_pins_pkg::PIN_DW-1:0] rd_bus,
  output logic out_valid_flag,
  output logic echo_pos,
  output logic echo_neg
);
  import sram_pins_pkg::*;

  // beat launched on the true clock rising edge
  rd_beat_t rise_r;
  rd_beat_t rise_nxt;
  // beat launched on the complementary clock rising edge
  rd_beat_t fall_r;
  rd_beat_t fall_nxt;

  // next values, cleared in reset so the bus reads idle
  always_comb begin
    rise_nxt = rst ? '0 : rise_in;
    fall_nxt = rst ? '0 : fall_in;
  end

  // true clock half
  always_ff @(posedge k_clk) begin
    rise_r <= rise_nxt;
  end

  // complementary edge is modelled as the falling edge of the true clock
  always_ff @(negedge k_clk) begin
    fall_r <= fall_nxt;
  end

  // pin mux: each half cycle shows the beat launched at its opening edge
  // valid and data switch on the same edge as the echo pair
  assign rd_bus = k_clk ? rise_r.data : fall_r.data;
  assign out_valid_flag = k_clk ? rise_r.vld : fall_r.vld;
  // echoes free run from the input clock, even with no data
  assign echo_pos = k_clk;
  assign echo_neg = ~k_clk;

  property p_echo_pair;
    @(posedge k_clk) echo_neg == !echo_pos;
  endproperty
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair not complementary");

  // a beat offered at the complementary edge is held in the fall half
  property p_fall_valid;
    @(negedge k_clk) disable iff (rst)
      fall_in.vld |=> fall_r.vld && fall_r.data == $past(fall_in.data);
  endproperty
  a_fall_valid: assert property (p_fall_valid) else $error("fall beat not held with valid");

  // sampled just before the true edge, while the pins still show the low half
  property p_fall_pin;
    @(posedge k_clk) disable iff (rst)
      fall_r.vld |-> out_valid_flag && rd_bus == fall_r.data;
  endproperty
  a_fall_pin: assert property (p_fall_pin) else $error("fall beat not on pins");

  // sampled just before the falling edge, while the pins show the high half
  property p_rise_pin;
    @(negedge k_clk) disable iff (rst)
      rise_r.vld |-> out_valid_flag && rd_bus == rise_r.data;
  endproperty
  a_rise_pin: assert property (p_rise_pin) else $error("rise beat not on pins");

endmodule

// ==== sim/sram_host_model.sv ====
`timescale 1ns/1ps
module sram_host_model (
  output logic k_clk,
  output sram_pins_pkg::link_cmd_t cmd,
  output logic [sram_pins_pkg::PIN_DW-1:0] wr_bus
);
  import sram_pins_pkg::*;

  // link clock at 12.5 MHz, well under the bypass-mode ceiling
  // runs free: the device needs it through reset and for its echoes
  initial begin
    k_clk = 1'b0;
    cmd = '{r_n: 1'b1, w_n: 1'b1, addr: '0};
    wr_bus = '0;
    #13;
    // falling edge stands in for the complementary clock, half a period late
    forever #40 k_clk = ~k_clk;
  end

  // one link cycle: command and beat0 ahead of the rising edge,
  // beat1 ahead of the falling edge that follows
  task automatic step(input logic rd, input logic wr, input logic [PIN_AW-1:0] a,
                      input logic [PIN_DW-1:0] d0, input logic [PIN_DW-1:0] d1);
    @(negedge k_clk);
    cmd.r_n <= ~rd;
    cmd.w_n <= ~wr;
    // an unselected address keeps churning so that a stray capture shows
    cmd.addr <= (rd | wr) ? a : ~cmd.addr;
    // idle lanes carry the inverse of the last value, never a stale copy
    wr_bus <= wr ? d0 : ~wr_bus;
    @(posedge k_clk);
    wr_bus <= wr ? d1 : ~wr_bus;
  endtask
endmodule

// ==== sim/ddr_sep_io_sram_pin_interface_test.sv ====
`timescale 1ns/1ps
module ddr_sep_io_sram_pin_interface_test;
  import sram_pins_pkg::*;

  logic clk;
  logic sys_rst;
  logic dll_off_n;
  logic k_clk;
  link_cmd_t cmd;
  logic [PIN_DW-1:0] wr_bus;
  logic [PIN_DW-1:0] rd_bus;
  logic [PIN_DW-1:0] rd_bus_narrow;
  logic out_valid_flag;
  logic valid_narrow;
  logic echo_pos;
  logic echo_neg;
  int miscompares = 0;
  int total_checks = 0;
  logic chk_on = 1'b0; // outputs are unknown until the link reset lands
  logic loop_on = 1'b0; // latency mode the model expects
  int last_rd = -10; // half-cycle index of the last accepted read
  logic [31:0] rnd = 32'd83215;
  logic [PIN_DW-1:0] mem [int]; // key: burst address * 2 + word
  logic [PIN_DW-1:0] exp_d [int]; // key: half-cycle index of a beat

  sram_host_model host (.k_clk(k_clk), .cmd(cmd), .wr_bus(wr_bus));

  ddr_sep_io_sram_pin_interface #(.X36(1'b1), .MEM_AW(8)) DUT (
    .clk(clk), .sys_rst(sys_rst), .k_clk(k_clk), .dll_off_n(dll_off_n), .cmd(cmd),
    .wr_bus(wr_bus), .rd_bus(rd_bus), .out_valid_flag(out_valid_flag),
    .echo_pos(echo_pos), .echo_neg(echo_neg));

  // narrow variant sees the same pins, full-width write data included
  ddr_sep_io_sram_pin_interface #(.X36(1'b0), .MEM_AW(8)) dut_narrow (
    .clk(clk), .sys_rst(sys_rst), .k_clk(k_clk), .dll_off_n(dll_off_n), .cmd(cmd),
    .wr_bus(wr_bus), .rd_bus(rd_bus_narrow), .out_valid_flag(valid_narrow),
    .echo_pos(), .echo_neg());

  // system clock, 100 MHz
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  task automatic check(input logic [PIN_DW-1:0] seen, input logic [PIN_DW-1:0] want,
                       input string what);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("unexpected at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  // one link cycle through the host, with the model updated alongside
  task automatic op(input logic rd, input logic wr, input logic [7:0] a);
    logic [PIN_DW-1:0] d0;
    logic [PIN_DW-1:0] d1;
    int h;
    rnd = lfsr(rnd);
    d0 = {rnd[3:0], rnd};
    rnd = lfsr(rnd);
    d1 = {rnd[7:4], rnd};
    // upper address bits random: they alias onto the stored bursts
    host.step(rd, wr, {rnd[11:0], a}, d0, d1);
    h = (int'($time) - 13) / 40;
    // write lands first, so a read on the same edge sees new data
    if (wr) begin
      mem[int'(a) * 2] = d0;
      mem[int'(a) * 2 + 1] = d1;
    end
    // a read one cycle after an accepted read is dropped
    if (rd && h - last_rd != 2) begin
      last_rd = h;
      exp_d[h + (loop_on ? 5 : 2)] = mem[int'(a) * 2];
      exp_d[h + (loop_on ? 6 : 3)] = mem[int'(a) * 2 + 1];
    end
  endtask

  // writes back to back, then reads with idle gaps, a refused read,
  // and a read sharing its edge with a write
  task automatic run_traffic();
    for (int i = 0; i < 8; i++) op(1'b0, 1'b1, 8'(i * 37));
    for (int i = 0; i < 8; i++) begin
      op(1'b1, i == 4, 8'(i * 37));
      op(i == 6, 1'b0, 8'((i + 1) * 37));
    end
    repeat (4) op(1'b0, 1'b0, 8'h00);
  endtask

  // sample mid-phase, where each beat stands settled
  always @(k_clk) begin
    logic [PIN_DW-1:0] want;
    int i;
    #20;
    i = (int'($time) - 33) / 40;
    want = exp_d.exists(i) ? exp_d[i] : '0;
    if (chk_on) begin
      check(rd_bus, want, "read data");
      check(PIN_DW'(out_valid_flag), PIN_DW'(exp_d.exists(i)), "valid");
      check(rd_bus_narrow, want & NARROW_MASK, "narrow data");
      check(PIN_DW'(valid_narrow), PIN_DW'(exp_d.exists(i)), "narrow valid");
      check(PIN_DW'(echo_pos), PIN_DW'(k_clk), "echo pos");
      check(PIN_DW'(echo_neg), PIN_DW'(!k_clk), "echo neg");
    end
  end

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    sys_rst = 1'b1;
    dll_off_n = 1'b0;
    // held in link cycles: the slow link must see the reset too
    repeat (3) @(posedge k_clk);
    chk_on = 1'b1;
    repeat (3) @(posedge k_clk);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge k_clk);
    run_traffic();
    @(posedge clk);
    dll_off_n <= 1'b1;
    // still bypass until the lock interval runs out
    run_traffic();
    repeat (LOCK_CYC + 40) @(posedge clk);
    loop_on = 1'b1;
    run_traffic();
    @(posedge clk);
    dll_off_n <= 1'b0;
    repeat (40) @(posedge clk);
    loop_on = 1'b0;
    run_traffic();
    end_of_test();
  end

  // watchdog, several times the expected run of about 31 us
  initial begin
    #200000;
    miscompares++;
    end_of_test();
  end
endmodule
